/* hw/spm_delay.sv */
// delay counter: counts a loaded number of cycles and flags expiry
`timescale 1ns/10ps
module spm_delay
    import spm_pkg::*;
(
    // clock and reset
    input  wire logic             clk_in,
    input  wire logic             reset_n_in,
    // control
    input  wire logic             load_in,
    input  wire logic [CNT_W-1:0] count_in,
    // status
    output logic                  expired_out
);
    logic [CNT_W-1:0] cnt_q;

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            cnt_q <= CNT_ZERO;
        end else if (load_in) begin
            cnt_q <= count_in;
        end else if (cnt_q != CNT_ZERO) begin
            cnt_q <= cnt_q - CNT_ONE;
        end
    end

    // a load of n flags the n-th cycle after it; the flag must not look at load_in,
    // because the sequencer loads on the flag itself
    assign expired_out = (cnt_q == CNT_ONE);
endmodule

/* hw/spm_host.sv */
// host controller driving a 16 x 1 scratch pad memory cell through its pins
// Behaviour
// - one X plus one Y line addresses one bit
// - all selects and writes low before access
// - write-one held at least 25 ns
// - write ended by returning input low
// - wait 40 ns recovery before sampling
// - full access cycle under 100 ns; a write here holds its selects for 4 cycles = 100 ns
`timescale 1ns/10ps
module spm_host
    import spm_pkg::*;
(
    // clock and reset
    input  wire logic              CLK_IN,
    input  wire logic              RESET_N_IN,
    // request side
    input  wire logic              REQ_VALID_IN,
    input  wire logic              REQ_WRITE_IN,
    input  wire logic [ADDR_W-1:0] REQ_ADDR_IN,
    input  wire logic              REQ_DATA_IN,
    output logic                   REQ_READY_OUT,
    // answer side
    output logic                   RSP_VALID_OUT,
    output logic                   RSP_DATA_OUT,
    output logic                   RSP_ERROR_OUT,
    // memory cell pins
    output logic [LINES-1:0]       X_SEL_OUT,
    output logic [LINES-1:0]       Y_SEL_OUT,
    output logic                   WRITE_ONE_OUT,
    output logic                   WRITE_ZERO_OUT,
    input  wire logic              SENSE_ONE_N_IN,
    input  wire logic              SENSE_ZERO_N_IN
);
    // ------------------------------------------------------------
    // state and storage
    // ------------------------------------------------------------
    spm_state_t       state_q;
    spm_pins_t        pins_q;
    logic             is_write_q;
    logic             wdata_q;
    logic             rsp_data_q;
    logic             rsp_err_q;
    logic [1:0]       s1_sync_q;
    logic [1:0]       s0_sync_q;
    logic             dly_load;
    logic [CNT_W-1:0] dly_count;
    logic             dly_done;

    // ------------------------------------------------------------
    // sense input synchronisers
    // ------------------------------------------------------------
    // the rails are asynchronous pins, two flops before use
    always_ff @(posedge CLK_IN) begin
        if (!RESET_N_IN) begin
            s1_sync_q <= 2'h3;
            s0_sync_q <= 2'h3;
        end else begin
            s1_sync_q <= {s1_sync_q[0], SENSE_ONE_N_IN};
            s0_sync_q <= {s0_sync_q[0], SENSE_ZERO_N_IN};
        end
    end

    // ------------------------------------------------------------
    // timing counter
    // ------------------------------------------------------------
    spm_delay u_delay (
        .clk_in      (CLK_IN),
        .reset_n_in  (RESET_N_IN),
        .load_in     (dly_load),
        .count_in    (dly_count),
        .expired_out (dly_done)
    );

    always_comb begin
        dly_load  = 1'b0;
        dly_count = CNT_ZERO;
        unique case (state_q)
            ST_IDLE: begin
                dly_load  = REQ_VALID_IN;
                dly_count = CNT_ONE;
            end
            ST_SELECT: begin
                dly_load  = dly_done;
                // a read also waits out the two synchroniser flops, so the
                // rail level sampled has settled for the full sense delay
                if (is_write_q) begin
                    dly_count = CNT_W'(WRITE_PULSE_CYC);
                end else begin
                    dly_count = CNT_W'(SENSE_DELAY_CYC + SYNC_CYC - 1);
                end
            end
            ST_WPULSE: begin
                dly_load  = dly_done;
                dly_count = CNT_W'(WRITE_RECOV_CYC);
            end
            ST_WRECOV, ST_SENSE, ST_DONE: begin
                dly_load  = 1'b0;
                dly_count = CNT_ZERO;
            end
        endcase
    end

    // ------------------------------------------------------------
    // access sequencer
    // ------------------------------------------------------------
    // a read is select, sense delay, sample: 3 cycles = 75 ns
    always_ff @(posedge CLK_IN) begin
        if (!RESET_N_IN) begin
            state_q <= ST_IDLE;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (REQ_VALID_IN) begin
                        state_q <= ST_SELECT;
                    end
                end
                ST_SELECT: begin
                    if (dly_done) begin
                        state_q <= is_write_q ? ST_WPULSE : ST_SENSE;
                    end
                end
                ST_WPULSE: begin
                    if (dly_done) begin
                        state_q <= ST_WRECOV;
                    end
                end
                ST_WRECOV: begin
                    if (dly_done) begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_SENSE: begin
                    if (dly_done) begin
                        state_q <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (!RESET_N_IN) begin
            is_write_q <= 1'b0;
            wdata_q    <= 1'b0;
        end else if (state_q == ST_IDLE && REQ_VALID_IN) begin
            is_write_q <= REQ_WRITE_IN;
            wdata_q    <= REQ_DATA_IN;
        end
    end

    // ------------------------------------------------------------
    // pin drive
    // ------------------------------------------------------------
    always_ff @(posedge CLK_IN) begin
        if (!RESET_N_IN) begin
            pins_q <= PINS_IDLE;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    pins_q <= PINS_IDLE;
                    if (REQ_VALID_IN) begin
                        // one-hot on each axis selects exactly one bit
                        pins_q.x_sel <= LINES'(1) << REQ_ADDR_IN[1:0];
                        pins_q.y_sel <= LINES'(1) << REQ_ADDR_IN[3:2];
                    end
                end
                ST_SELECT: if (dly_done && is_write_q) begin
                    pins_q.write_one  <= wdata_q;
                    pins_q.write_zero <= !wdata_q;
                end
                ST_WPULSE: if (dly_done) begin
                    pins_q.write_one  <= 1'b0;
                    pins_q.write_zero <= 1'b0;
                end
                ST_WRECOV: begin
                    // selects stay up through recovery: simple, but a write costs 4 cycles
                    if (dly_done) begin
                        pins_q <= PINS_IDLE;
                    end
                end
                ST_SENSE: begin
                    if (dly_done) begin
                        pins_q <= PINS_IDLE;
                    end
                end
                ST_DONE: begin
                    pins_q <= PINS_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // read answer
    // ------------------------------------------------------------
    // rails are only sampled after sense delay, never during a write
    always_ff @(posedge CLK_IN) begin
        if (!RESET_N_IN) begin
            rsp_data_q <= 1'b0;
            rsp_err_q  <= 1'b0;
        end else if (state_q == ST_SENSE && dly_done) begin
            rsp_data_q <= !s1_sync_q[1];
            rsp_err_q  <= (s1_sync_q[1] == s0_sync_q[1]);
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign REQ_READY_OUT  = (state_q == ST_IDLE);
    assign RSP_VALID_OUT  = (state_q == ST_DONE);
    assign RSP_DATA_OUT   = rsp_data_q;
    assign RSP_ERROR_OUT  = rsp_err_q;
    assign X_SEL_OUT      = pins_q.x_sel;
    assign Y_SEL_OUT      = pins_q.y_sel;
    assign WRITE_ONE_OUT  = pins_q.write_one;
    assign WRITE_ZERO_OUT = pins_q.write_zero;
endmodule

/* hw/spm_pkg.sv */
// package: constants and types for the scratch pad bit memory host controller
package spm_pkg;
    // clock and timing
    localparam int CLK_PERIOD_NS   = 25;
    localparam int WRITE_PULSE_NS  = 25;
    localparam int WRITE_RECOV_NS  = 40;
    localparam int SENSE_DELAY_NS  = 25;
    localparam int WRITE_PULSE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WRITE_RECOV_CYC = (WRITE_RECOV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SENSE_DELAY_CYC = (SENSE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // sense rails reach the logic two edges late through the synchroniser
    localparam int SYNC_CYC        = 2;
    localparam int CNT_W           = 4;
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
    localparam logic [CNT_W-1:0] CNT_ONE  = 4'h1;

    // matrix geometry
    localparam int LINES  = 4;
    localparam int ADDR_W = 4;

    // pin group driven toward the memory cell
    typedef struct packed {
        logic [LINES-1:0] x_sel;
        logic [LINES-1:0] y_sel;
        logic             write_one;
        logic             write_zero;
    } spm_pins_t;

    localparam spm_pins_t PINS_IDLE = '0;

    typedef enum logic [5:0] {
        ST_IDLE   = 6'h01,
        ST_SELECT = 6'h02,
        ST_WPULSE = 6'h04,
        ST_WRECOV = 6'h08,
        ST_SENSE  = 6'h10,
        ST_DONE   = 6'h20
    } spm_state_t;
endpackage

/* tb/spm_cell_model.sv */
// behavioural 16 x 1 memory cell seen at the controller pins
`timescale 1ns/10ps
module spm_cell_model (
    // select and write pins
    input  wire logic [3:0] x_sel_in,
    input  wire logic [3:0] y_sel_in,
    input  wire logic       write_one_in,
    input  wire logic       write_zero_in,
    // no cell on the rails: both float to the pull-up
    input  wire logic       fault_in,
    // rails after the external pull-up
    output logic            sense_one_n_out,
    output logic            sense_zero_n_out
);
    logic [15:0] mem = 16'h0000;
    logic        recov = 1'b0;
    wire logic   sel = $onehot(x_sel_in) && $onehot(y_sel_in);
    wire logic [3:0] idx = {y_sel_in[2] | y_sel_in[3], y_sel_in[1] | y_sel_in[3],
                            x_sel_in[2] | x_sel_in[3], x_sel_in[1] | x_sel_in[3]};
    always @* begin
        if (sel && write_one_in)
            mem[idx] = 1'b1;
        else if (sel && write_zero_in)
            mem[idx] = 1'b0;
    end
    // a second write inside 40 ns ends recovery early; the controller never does that
    always @(negedge write_one_in or negedge write_zero_in) begin
        recov = 1'b1;
        #40 recov = 1'b0;
    end
    always @* begin
        if (!sel || fault_in)
            {sense_one_n_out, sense_zero_n_out} = 2'b11;
        else if (write_one_in || write_zero_in || recov)
            {sense_one_n_out, sense_zero_n_out} = {mem[idx], ~mem[idx]};
        else
            {sense_one_n_out, sense_zero_n_out} = {~mem[idx], mem[idx]};
    end
endmodule

/* tb/spm_host_assertions.sv */
// pin-level assertions for the scratch pad host controller
`timescale 1ns/10ps
module spm_host_assertions
    import spm_pkg::*;
(
    // clock and reset
    input  wire logic              CLK_IN,
    input  wire logic              RESET_N_IN,
    // request side
    input  wire logic              REQ_VALID_IN,
    input  wire logic              REQ_WRITE_IN,
    input  wire logic [ADDR_W-1:0] REQ_ADDR_IN,
    input  wire logic              REQ_READY_OUT,
    input  wire logic              RSP_VALID_OUT,
    // memory cell pins
    input  wire logic [LINES-1:0]  X_SEL_OUT,
    input  wire logic [LINES-1:0]  Y_SEL_OUT,
    input  wire logic              WRITE_ONE_OUT,
    input  wire logic              WRITE_ZERO_OUT
);
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (!RESET_N_IN);

    logic              tk;
    logic              wr;
    logic [ADDR_W-1:0] adr_q;

    assign tk = REQ_VALID_IN && REQ_READY_OUT;
    assign wr = WRITE_ONE_OUT || WRITE_ZERO_OUT;

    // address of the access in flight, to judge the select lines
    always_ff @(posedge CLK_IN) begin
        if (tk) begin
            adr_q <= REQ_ADDR_IN;
        end
    end

    a_sel_onehot: assert property ($onehot0(X_SEL_OUT) && $onehot0(Y_SEL_OUT))
        else $error("select lines not one-hot");
    a_sel_addr: assert property (X_SEL_OUT != 4'h0 |->
        X_SEL_OUT == 4'h1 << adr_q[1:0] && Y_SEL_OUT == 4'h1 << adr_q[3:2])
        else $error("select lines do not match address");
    a_idle_take: assert property (tk |-> X_SEL_OUT == 4'h0 && Y_SEL_OUT == 4'h0 && !wr)
        else $error("pins not idle at request");
    a_ready_idle: assert property (REQ_READY_OUT |-> X_SEL_OUT == 4'h0 && !wr)
        else $error("pins active while ready");
    a_wr_sel: assert property (wr |-> X_SEL_OUT != 4'h0 && !(WRITE_ONE_OUT && WRITE_ZERO_OUT))
        else $error("write pulse without single target");
    a_sel_first: assert property ($rose(wr) |-> $past(X_SEL_OUT) != 4'h0)
        else $error("write pulse before selection");
    a_one_width: assert property ($rose(WRITE_ONE_OUT) |=> !WRITE_ONE_OUT)
        else $error("write-one pulse not ended");
    a_zero_width: assert property ($rose(WRITE_ZERO_OUT) |=> !WRITE_ZERO_OUT)
        else $error("write-zero pulse not ended");
    a_recov_hold: assert property ($fell(wr) |-> (X_SEL_OUT != 4'h0)[*2])
        else $error("recovery cut short");
    a_no_rsp_wr: assert property (wr |-> !RSP_VALID_OUT ##1 !RSP_VALID_OUT ##1 !RSP_VALID_OUT)
        else $error("answer during write");
    a_read_lat: assert property (tk && !REQ_WRITE_IN |-> ##[3:5] RSP_VALID_OUT)
        else $error("read answer late");
    a_rsp_pulse: assert property (RSP_VALID_OUT |=> !RSP_VALID_OUT)
        else $error("answer longer than one cycle");
endmodule
bind spm_host spm_host_assertions u_chk (.CLK_IN(CLK_IN), .RESET_N_IN(RESET_N_IN),
    .REQ_VALID_IN(REQ_VALID_IN), .REQ_WRITE_IN(REQ_WRITE_IN), .REQ_ADDR_IN(REQ_ADDR_IN),
    .REQ_READY_OUT(REQ_READY_OUT), .RSP_VALID_OUT(RSP_VALID_OUT), .X_SEL_OUT(X_SEL_OUT),
    .Y_SEL_OUT(Y_SEL_OUT), .WRITE_ONE_OUT(WRITE_ONE_OUT), .WRITE_ZERO_OUT(WRITE_ZERO_OUT));

/* tb/tb_spm_host.sv */
// self-checking bench for the scratch pad host controller
`timescale 1ns/10ps
module tb_spm_host;
    import spm_pkg::*;
    // ------------------------------------------------------------
    // signals and instances
    // ------------------------------------------------------------
    localparam int          LIMIT = 20;
    localparam logic [15:0] PAT   = 16'ha5c3;
    logic                   clk   = 1'b0;
    logic                   rst_n = 1'b0;
    logic                   vld   = 1'b0;
    logic                   wrt   = 1'b0;
    logic                   dat   = 1'b0;
    logic                   flt   = 1'b0;
    logic [ADDR_W-1:0]      adr   = 4'h0;
    logic                   rdy;
    logic                   rv;
    logic                   rd;
    logic                   re;
    logic                   w1;
    logic                   w0;
    logic                   s1n;
    logic                   s0n;
    logic [LINES-1:0]       xs;
    logic [LINES-1:0]       ys;
    int                     fails     = 0;
    int                     cmp_count = 0;
    spm_host u_dut (.CLK_IN(clk), .RESET_N_IN(rst_n), .REQ_VALID_IN(vld), .REQ_WRITE_IN(wrt),
        .REQ_ADDR_IN(adr), .REQ_DATA_IN(dat), .REQ_READY_OUT(rdy), .RSP_VALID_OUT(rv),
        .RSP_DATA_OUT(rd), .RSP_ERROR_OUT(re), .X_SEL_OUT(xs), .Y_SEL_OUT(ys),
        .WRITE_ONE_OUT(w1), .WRITE_ZERO_OUT(w0), .SENSE_ONE_N_IN(s1n), .SENSE_ZERO_N_IN(s0n));
    spm_cell_model u_cell (.x_sel_in(xs), .y_sel_in(ys), .write_one_in(w1),
        .write_zero_in(w0), .fault_in(flt), .sense_one_n_out(s1n), .sense_zero_n_out(s0n));
    initial begin
        forever #12.5 clk = ~clk;
    end
    task automatic check(input logic [1:0] seen, input logic [1:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %0t seen %b want %b", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("checks %0d fails %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // entered just after an edge; returns just after ready (write) or answer (read)
    task automatic acc(input logic w, input logic [3:0] a, input logic d);
        int n;
        n = 0;
        vld = 1'b1;
        wrt = w;
        adr = a;
        dat = d;
        // ready is judged settled, one step after the edge that set it
        while (rdy !== 1'b1 && n < LIMIT) begin
            @(posedge clk);
            #1 n++;
        end
        if (rdy !== 1'b1) begin
            fails++;
            test_done();
        end
        @(posedge clk);
        #1 vld = 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            #1 n++;
        end while ((w ? rdy : rv) !== 1'b1 && n < LIMIT);
        if ((w ? rdy : rv) !== 1'b1) begin
            fails++;
            test_done();
        end
        if (!w) begin
            check({1'b0, n < 4}, 2'b01);
        end
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic e);
        acc(1'b0, a, 1'b0);
        check({re, rd}, {1'b0, e});
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        @(posedge clk);
        #1 check({rdy, w1 | w0 | (|xs) | (|ys)}, 2'b10);
        check({rv, re | rd}, 2'b00);
        @(posedge clk);
        #1 rst_n = 1'b1;
        $display("reset test ended");
    endtask
    task automatic t_fill();
        for (int i = 0; i < 16; i++) begin
            acc(1'b1, i[3:0], PAT[i]);
        end
        for (int i = 0; i < 32; i++) begin
            rd_chk(i[3:0], PAT[i % 16]);
        end
        $display("fill and reread test ended");
    endtask
    task automatic t_overwrite();
        acc(1'b1, 4'hf, 1'b0);
        acc(1'b1, 4'hf, 1'b1);
        rd_chk(4'hf, 1'b1);
        acc(1'b1, 4'hf, 1'b0);
        rd_chk(4'hf, 1'b0);
        $display("overwrite test ended");
    endtask
    task automatic t_fault();
        flt = 1'b1;
        acc(1'b0, 4'h5, 1'b0);
        check({re, rd}, 2'b10);
        flt = 1'b0;
        rd_chk(4'h5, PAT[5]);
        $display("empty rail test ended");
    endtask
    // reset lands while a read holds its selects; the cell keeps its contents
    task automatic t_midreset();
        rd_chk(4'h0, PAT[0]);
        @(posedge clk);
        #1 vld = 1'b1;
        wrt = 1'b0;
        adr = 4'h0;
        @(posedge clk);
        #1 vld = 1'b0;
        @(posedge clk);
        #1 check({|xs, |ys}, 2'b11);
        rst_n = 1'b0;
        @(posedge clk);
        #1 check({rdy, w1 | w0 | (|xs) | (|ys)}, 2'b10);
        check({rv, re | rd}, 2'b00);
        @(posedge clk);
        #1 rst_n = 1'b1;
        rd_chk(4'h0, PAT[0]);
        $display("mid-run reset test ended");
    endtask
    initial begin
        t_reset();
        t_fill();
        t_overwrite();
        t_fault();
        t_midreset();
        test_done();
    end
endmodule
